/* File: core/xcc_pkg.sv */
// constants, state type and byte-packing helpers of the extremes block
package xcc_pkg;

	// register offsets
	localparam logic [7:0] ADDR_MIN_TEMP_HIGH = 8'h1F;
	localparam logic [7:0] ADDR_MIN_TEMP_LOW = 8'h20;
	localparam logic [7:0] ADDR_MAX_PRES_HIGH = 8'h21;
	localparam logic [7:0] ADDR_MAX_PRES_MID = 8'h22;
	localparam logic [7:0] ADDR_MAX_PRES_LOW = 8'h23;
	localparam logic [7:0] ADDR_MAX_TEMP_HIGH = 8'h24;
	localparam logic [7:0] ADDR_MAX_TEMP_LOW = 8'h25;
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h26;

	// control register field positions
	localparam int CTRL_OS_MSB = 5;
	localparam int CTRL_OS_LSB = 3;
	localparam int CTRL_SRST_BIT = 2;
	localparam int CTRL_OST_BIT = 1;
	localparam int CTRL_SBY_BIT = 0;

	// widths and values after reset
	localparam int PRES_W = 20;
	localparam int TEMP_W = 12;
	localparam logic [PRES_W-1:0] PRES_RESET = 20'h00000;
	localparam logic [TEMP_W-1:0] TEMP_RESET = 12'h000;
	localparam logic [2:0] OS_RESET = 3'h0;
	localparam logic [7:0] RATIO_RESET = 8'h01;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// sequencer states, gray along idle -> standby -> reload
	typedef enum logic [1:0] {
		XCC_IDLE = 2'b00,
		XCC_SRST_STBY = 2'b01,
		XCC_SRST_LOAD = 2'b11,
		XCC_MEAS = 2'b10
	} xcc_seq_e;

	// merge one written byte into a 12-bit temperature
	function automatic logic [TEMP_W-1:0] xcc_temp_merge(
			input logic [TEMP_W-1:0] cur, input logic high,
			input logic [7:0] data);
		xcc_temp_merge = high ? {data, cur[3:0]} : {cur[11:4], data[7:4]};
	endfunction : xcc_temp_merge

	// low byte of a temperature: fraction on top, reserved zero below
	function automatic logic [7:0] xcc_temp_low(input logic [TEMP_W-1:0] v);
		xcc_temp_low = {v[3:0], 4'h0};
	endfunction : xcc_temp_low

endpackage : xcc_pkg

/* File: core/xcc_extreme.sv */
// one captured extreme value with software write and sample compare
`timescale 1ns/1ns
module xcc_extreme #(
	parameter int W = 12,
	parameter bit FIND_MAX = 1'b1,
	parameter bit SIGNED_CMP = 1'b0
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic clear_in,
	input wire logic wr_in,
	input wire logic [W-1:0] wr_value_in,
	input wire logic sample_valid_in,
	input wire logic [W-1:0] sample_in,
	output logic [W-1:0] value_out
);

	logic [W-1:0] value_reg;
	logic [W-1:0] value_next;
	logic [W-1:0] base;
	logic beats;

	// write lands first, a sample in the same cycle is compared against it
	always_comb begin
		base = wr_in ? wr_value_in : value_reg;
		if (SIGNED_CMP) begin
			beats = FIND_MAX ? ($signed(sample_in) > $signed(base)) :
				($signed(sample_in) < $signed(base));
		end else begin
			beats = FIND_MAX ? (sample_in > base) : (sample_in < base);
		end
		value_next = base;
		if (clear_in) begin
			value_next = '0;
		end else if (sample_valid_in && beats) begin
			value_next = sample_in;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			value_reg <= '0;
		end else begin
			value_reg <= value_next;
		end
	end

	assign value_out = value_reg;

endmodule : xcc_extreme

/* File: core/xcc_top.sv */
// captured extremes store and first measurement control register
//
// Overview of operation
// R01 - max pressure: unsigned 20 bits, 18 integer
// R02 - pressure low byte bits 5:4 hold fraction
// R03 - max pressure at 21h-23h, low nibble reserved
// R04 - temperatures signed 12 bits, integer in high
// R05 - temperature fraction in low byte bits 7:4
// R06 - min temperature at 1Fh and 20h
// R07 - max temperature at 24h and 25h
// R08 - extremes zero at reset, host clears by writing
// R09 - host changes fields only while in standby
// R10 - control register 26h layout, resets to zero
// R11 - completed sample replaces a beaten extreme
// R12 - reserved bits ignore writes, read zero
// R13 - oversample ratio is two to the field
// R14 - software reset: standby, reload, reset interface
// R15 - one-shot measures once, self-clears in standby
// R16 - standby select zero holds standby, one periodic
`timescale 1ns/1ns
module xcc_top (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic period_tick_in,
	input wire logic meas_done_in,
	input wire logic [19:0] sample_pressure_in,
	input wire logic [11:0] sample_temp_in,
	output logic meas_start_out,
	output logic [7:0] oversample_ratio_out,
	output logic active_mode_out,
	output logic serial_reset_out
);

	xcc_pkg::xcc_seq_e state_reg;
	xcc_pkg::xcc_seq_e state_next;
	logic [2:0] oversample_select_reg;
	logic [2:0] oversample_select_next;
	logic one_shot_trigger_reg;
	logic one_shot_trigger_next;
	logic standby_active_select_reg;
	logic standby_active_select_next;
	logic shot_pend_reg;
	logic shot_pend_next;
	logic start_reg;
	logic start_next;
	logic srst_pulse_reg;
	logic srst_pulse_next;
	logic [7:0] ratio_reg;
	logic [7:0] ratio_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic wr_open;
	logic ctrl_wr;
	logic shot_set;
	logic shot_clr;
	logic sample_valid;
	logic load_defaults;
	logic [19:0] max_pres;
	logic [11:0] min_temp;
	logic [11:0] max_temp;
	logic [19:0] max_pres_wval;
	logic [11:0] min_temp_wval;
	logic [11:0] max_temp_wval;
	logic max_pres_wr;
	logic min_temp_wr;
	logic max_temp_wr;

	// host writes are refused while the software reset runs
	assign wr_open = reg_wr_in && (state_reg == xcc_pkg::XCC_IDLE ||
		state_reg == xcc_pkg::XCC_MEAS);
	assign ctrl_wr = wr_open && reg_addr_in == xcc_pkg::ADDR_CTRL_ONE;
	assign shot_set = ctrl_wr && !reg_wdata_in[xcc_pkg::CTRL_SRST_BIT] &&
		reg_wdata_in[xcc_pkg::CTRL_OST_BIT] && !one_shot_trigger_reg;
	assign sample_valid = meas_done_in && state_reg == xcc_pkg::XCC_MEAS;
	assign load_defaults = state_reg == xcc_pkg::XCC_SRST_LOAD;

	// control register and measurement sequencer next state
	always_comb begin
		state_next = state_reg;
		oversample_select_next = oversample_select_reg;
		one_shot_trigger_next = one_shot_trigger_reg;
		standby_active_select_next = standby_active_select_reg;
		start_next = 1'b0;
		srst_pulse_next = 1'b0;
		shot_clr = 1'b0;
		// fields stored as written; host keeps to standby for them [R09]
		if (ctrl_wr) begin
			if (reg_wdata_in[xcc_pkg::CTRL_SRST_BIT]) begin
				state_next = xcc_pkg::XCC_SRST_STBY; // [R14]
			end else begin
				oversample_select_next =
					reg_wdata_in[xcc_pkg::CTRL_OS_MSB:xcc_pkg::CTRL_OS_LSB]; // [R10]
				one_shot_trigger_next = reg_wdata_in[xcc_pkg::CTRL_OST_BIT];
				standby_active_select_next =
					reg_wdata_in[xcc_pkg::CTRL_SBY_BIT]; // [R16]
			end
		end
		case (state_reg)
			xcc_pkg::XCC_IDLE: begin
				// one-shot or periodic tick starts a measurement [R15] [R16]
				if (state_next == xcc_pkg::XCC_IDLE && (shot_pend_reg ||
						(standby_active_select_reg && period_tick_in))) begin
					start_next = 1'b1;
					shot_clr = 1'b1;
					state_next = xcc_pkg::XCC_MEAS;
				end
			end
			xcc_pkg::XCC_MEAS: begin
				if (meas_done_in && state_next == xcc_pkg::XCC_MEAS) begin
					state_next = xcc_pkg::XCC_IDLE;
					// one-shot self-clears only in standby [R15]
					if (!standby_active_select_reg && !shot_set) begin
						one_shot_trigger_next = 1'b0;
					end
				end
			end
			xcc_pkg::XCC_SRST_STBY: begin
				standby_active_select_next = 1'b0; // [R14]
				state_next = xcc_pkg::XCC_SRST_LOAD;
			end
			xcc_pkg::XCC_SRST_LOAD: begin
				oversample_select_next = xcc_pkg::OS_RESET; // [R14]
				one_shot_trigger_next = 1'b0;
				standby_active_select_next = 1'b0;
				shot_clr = 1'b1;
				srst_pulse_next = 1'b1;
				state_next = xcc_pkg::XCC_IDLE;
			end
			default: begin
				state_next = xcc_pkg::XCC_IDLE;
			end
		endcase
		// a new one-shot request wins over the consume of an old one
		shot_pend_next = (shot_pend_reg && !shot_clr) || shot_set;
		ratio_next = 8'h01 << oversample_select_next; // [R13]
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= xcc_pkg::XCC_IDLE;
			oversample_select_reg <= xcc_pkg::OS_RESET;
			one_shot_trigger_reg <= 1'b0;
			standby_active_select_reg <= 1'b0;
			shot_pend_reg <= 1'b0;
			start_reg <= 1'b0;
			srst_pulse_reg <= 1'b0;
			ratio_reg <= xcc_pkg::RATIO_RESET;
		end else begin
			state_reg <= state_next;
			oversample_select_reg <= oversample_select_next;
			one_shot_trigger_reg <= one_shot_trigger_next;
			standby_active_select_reg <= standby_active_select_next;
			shot_pend_reg <= shot_pend_next;
			start_reg <= start_next;
			srst_pulse_reg <= srst_pulse_next;
			ratio_reg <= ratio_next;
		end
	end

	// byte writes merged into the held extremes [R03] [R06] [R07] [R08]
	always_comb begin
		max_pres_wr = wr_open && (reg_addr_in == xcc_pkg::ADDR_MAX_PRES_HIGH ||
			reg_addr_in == xcc_pkg::ADDR_MAX_PRES_MID ||
			reg_addr_in == xcc_pkg::ADDR_MAX_PRES_LOW);
		min_temp_wr = wr_open && (reg_addr_in == xcc_pkg::ADDR_MIN_TEMP_HIGH ||
			reg_addr_in == xcc_pkg::ADDR_MIN_TEMP_LOW);
		max_temp_wr = wr_open && (reg_addr_in == xcc_pkg::ADDR_MAX_TEMP_HIGH ||
			reg_addr_in == xcc_pkg::ADDR_MAX_TEMP_LOW);
		max_pres_wval = max_pres;
		case (reg_addr_in)
			xcc_pkg::ADDR_MAX_PRES_HIGH: max_pres_wval[19:12] = reg_wdata_in;
			xcc_pkg::ADDR_MAX_PRES_MID: max_pres_wval[11:4] = reg_wdata_in;
			default: max_pres_wval[3:0] = reg_wdata_in[7:4]; // [R12]
		endcase
		min_temp_wval = xcc_pkg::xcc_temp_merge(min_temp,
			reg_addr_in == xcc_pkg::ADDR_MIN_TEMP_HIGH, reg_wdata_in);
		max_temp_wval = xcc_pkg::xcc_temp_merge(max_temp,
			reg_addr_in == xcc_pkg::ADDR_MAX_TEMP_HIGH, reg_wdata_in);
	end

	// pressure maximum, unsigned compare [R01] [R11]
	xcc_extreme #(.W(xcc_pkg::PRES_W), .FIND_MAX(1'b1), .SIGNED_CMP(1'b0))
	u_max_pres (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.clear_in(load_defaults),
		.wr_in(max_pres_wr),
		.wr_value_in(max_pres_wval),
		.sample_valid_in(sample_valid),
		.sample_in(sample_pressure_in),
		.value_out(max_pres)
	);

	// temperature minimum, signed compare [R04] [R11]
	xcc_extreme #(.W(xcc_pkg::TEMP_W), .FIND_MAX(1'b0), .SIGNED_CMP(1'b1))
	u_min_temp (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.clear_in(load_defaults),
		.wr_in(min_temp_wr),
		.wr_value_in(min_temp_wval),
		.sample_valid_in(sample_valid),
		.sample_in(sample_temp_in),
		.value_out(min_temp)
	);

	// temperature maximum, signed compare [R04] [R11]
	xcc_extreme #(.W(xcc_pkg::TEMP_W), .FIND_MAX(1'b1), .SIGNED_CMP(1'b1))
	u_max_temp (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.clear_in(load_defaults),
		.wr_in(max_temp_wr),
		.wr_value_in(max_temp_wval),
		.sample_valid_in(sample_valid),
		.sample_in(sample_temp_in),
		.value_out(max_temp)
	);

	// read data registered one cycle after the read strobe
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_rd_in) begin
			case (reg_addr_in)
				xcc_pkg::ADDR_MIN_TEMP_HIGH: rdata_next = min_temp[11:4]; // [R06]
				xcc_pkg::ADDR_MIN_TEMP_LOW:
					rdata_next = xcc_pkg::xcc_temp_low(min_temp); // [R05]
				xcc_pkg::ADDR_MAX_PRES_HIGH: rdata_next = max_pres[19:12]; // [R03]
				xcc_pkg::ADDR_MAX_PRES_MID: rdata_next = max_pres[11:4];
				xcc_pkg::ADDR_MAX_PRES_LOW:
					rdata_next = {max_pres[3:0], 4'h0}; // [R02] [R12]
				xcc_pkg::ADDR_MAX_TEMP_HIGH: rdata_next = max_temp[11:4]; // [R07]
				xcc_pkg::ADDR_MAX_TEMP_LOW:
					rdata_next = xcc_pkg::xcc_temp_low(max_temp);
				xcc_pkg::ADDR_CTRL_ONE:
					rdata_next = {2'b00, oversample_select_reg, 1'b0,
						one_shot_trigger_reg, standby_active_select_reg}; // [R10]
				default: rdata_next = xcc_pkg::RDATA_RESET;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_reg <= xcc_pkg::RDATA_RESET;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign meas_start_out = start_reg;
	assign oversample_ratio_out = ratio_reg;
	assign active_mode_out = standby_active_select_reg;
	assign serial_reset_out = srst_pulse_reg;

	// checks on the block's own behaviour
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	AST_RATIO: assert property (ctrl_wr && !reg_wdata_in[2] |-> ##1 // [R13]
		oversample_ratio_out == (8'h01 << $past(reg_wdata_in[5:3])))
		else $error("oversample ratio does not follow field");
	AST_RES_LOW: assert property (reg_rd_in && // [R12]
		(reg_addr_in == xcc_pkg::ADDR_MAX_PRES_LOW ||
		reg_addr_in == xcc_pkg::ADDR_MIN_TEMP_LOW ||
		reg_addr_in == xcc_pkg::ADDR_MAX_TEMP_LOW) |=> reg_rdata_out[3:0] == 4'h0)
		else $error("reserved low bits read nonzero");
	AST_CTRL_RD: assert property (reg_rd_in && // [R10]
		reg_addr_in == xcc_pkg::ADDR_CTRL_ONE |=>
		reg_rdata_out[7:6] == 2'b00 && !reg_rdata_out[2])
		else $error("control reserved or reset bit read nonzero");
	AST_SRST_SEQ: assert property (ctrl_wr && reg_wdata_in[2] |=> // [R14]
		##1 !active_mode_out ##1
		(serial_reset_out && !active_mode_out && oversample_ratio_out == 8'h01)
		##1 !serial_reset_out)
		else $error("software reset sequence wrong");
	AST_STANDBY_QUIET: assert property (!standby_active_select_reg && // [R16]
		!shot_pend_reg |=> !meas_start_out)
		else $error("measurement started in standby without request");
	AST_PERIODIC: assert property (state_reg == xcc_pkg::XCC_IDLE && // [R16]
		!ctrl_wr && standby_active_select_reg && period_tick_in |=> meas_start_out)
		else $error("periodic tick did not start a measurement");
	AST_OST_CLEAR: assert property (sample_valid && // [R15]
		!standby_active_select_reg && !ctrl_wr |=> !one_shot_trigger_reg)
		else $error("one-shot did not clear in standby");
	AST_OST_HOLD: assert property (sample_valid && // [R15]
		standby_active_select_reg && one_shot_trigger_reg && !ctrl_wr |=>
		one_shot_trigger_reg)
		else $error("one-shot cleared itself in active mode");
	AST_PMAX: assert property (sample_valid && !max_pres_wr && !load_defaults &&
		sample_pressure_in > max_pres |=> // [R11]
		max_pres == $past(sample_pressure_in))
		else $error("max pressure not captured");
	AST_TMIN: assert property (sample_valid && !min_temp_wr && !load_defaults &&
		$signed(sample_temp_in) < $signed(min_temp) |=> // [R11]
		min_temp == $past(sample_temp_in))
		else $error("min temperature not captured");
	AST_CLEAR: assert property (max_temp_wr && !sample_valid && // [R08]
		reg_addr_in == xcc_pkg::ADDR_MAX_TEMP_HIGH && reg_wdata_in == 8'h00 |=>
		max_temp[11:4] == 8'h00)
		else $error("max temperature high byte not cleared");

endmodule : xcc_top

/* File: bench/xcc_meas_model.sv */
// behavioural measurement engine answering the start pulse
`timescale 1ns/1ns
module xcc_meas_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic [3:0] delay_in,
	input wire logic [19:0] pres_in,
	input wire logic [11:0] temp_in,
	output logic done_out,
	output logic [19:0] pres_out,
	output logic [11:0] temp_out
);
	logic busy;
	logic [3:0] cnt;
	// one done pulse per start; samples scrambled outside done
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			done_out <= 1'b0;
			pres_out <= 20'h00000;
			temp_out <= 12'h000;
		end else begin
			done_out <= busy && cnt == 4'h0;
			pres_out <= (busy && cnt == 4'h0) ? pres_in : ~pres_out;
			temp_out <= (busy && cnt == 4'h0) ? temp_in : ~temp_out;
			if (start_in) begin
				busy <= 1'b1;
				cnt <= delay_in;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule : xcc_meas_model

/* File: bench/xcc_top_tb.sv */
// self-checking bench of the extremes store and control register
`timescale 1ns/1ns
module xcc_top_tb;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic period_tick_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] reg_rdata_out, oversample_ratio_out;
	logic meas_done_in, meas_start_out, active_mode_out, serial_reset_out;
	logic [19:0] sample_pressure_in, sp = 20'h00000, mp = 20'h00000;
	logic [11:0] sample_temp_in, st = 12'h000, tmin = 12'h000;
	logic [11:0] tmax = 12'h000;
	logic [3:0] dly = 4'h1;
	logic [31:0] seed = 32'h0FF8;
	logic [7:0] exp_q[$];
	logic [7:0] msk[7] = '{8'hFF, 8'hF0, 8'hFF, 8'hFF, 8'hF0, 8'hFF, 8'hF0};
	logic rd_d = 1'b0;
	logic act_sel = 1'b0;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	always #5 core_clk_in = ~core_clk_in;
	xcc_top i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .period_tick_in(period_tick_in),
		.meas_done_in(meas_done_in), .sample_pressure_in(sample_pressure_in),
		.sample_temp_in(sample_temp_in), .meas_start_out(meas_start_out),
		.oversample_ratio_out(oversample_ratio_out),
		.active_mode_out(active_mode_out),
		.serial_reset_out(serial_reset_out));
	xcc_meas_model i_eng (.clk_in(core_clk_in), .rst_in(rst_in),
		.start_in(meas_start_out), .delay_in(dly), .pres_in(sp),
		.temp_in(st), .done_out(meas_done_in),
		.pres_out(sample_pressure_in), .temp_out(sample_temp_in));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		v = v ^ (v << 5);
		return v;
	endfunction : xs
	task chk(input logic [19:0] got, input logic [19:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop
	// read data lands one cycle after the read edge
	always @(posedge core_clk_in) rd_d <= reg_rd_in;
	always @(negedge core_clk_in) begin
		if (rd_d === 1'b1) begin
			chk(reg_rdata_out, exp_q.pop_front());
		end
	end
	// hang guard
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop;
		end
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		#1 reg_wr_in = 1'b1;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(posedge core_clk_in);
		#1 reg_wr_in = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk_in);
		#1 reg_rd_in = 1'b1;
		reg_addr_in = a;
		exp_q.push_back(e);
		@(posedge core_clk_in);
		#1 reg_rd_in = 1'b0;
	endtask : rd
	task rd_all;
		rd(8'h1F, tmin[11:4]);
		rd(8'h20, {tmin[3:0], 4'h0});
		rd(8'h21, mp[19:12]);
		rd(8'h22, mp[11:4]);
		rd(8'h23, {mp[3:0], 4'h0});
		rd(8'h24, tmax[11:4]);
		rd(8'h25, {tmax[3:0], 4'h0});
	endtask : rd_all
	// one measurement by one-shot or by periodic tick
	task measure(input bit tick);
		int n;
		seed = xs(seed);
		sp = seed[19:0];
		st = seed[31:20];
		dly = seed[23:20] & 4'h7;
		if (sp > mp) mp = sp;
		if ($signed(st) > $signed(tmax)) tmax = st;
		if ($signed(st) < $signed(tmin)) tmin = st;
		if (tick) begin
			@(posedge core_clk_in);
			#1 period_tick_in = 1'b1;
			@(posedge core_clk_in);
			#1 period_tick_in = 1'b0;
		end else begin
			wr(8'h26, {6'h00, 1'b1, act_sel});
		end
		n = 0;
		while (meas_start_out !== 1'b1 && n < 20) begin
			@(negedge core_clk_in);
			n++;
		end
		chk(n < 20, 1'b1);
		repeat (12) @(posedge core_clk_in);
		if (!tick) rd(8'h26, {6'h00, act_sel, act_sel});
	endtask : measure
	initial begin
		repeat (12) @(posedge core_clk_in);
		#1 rst_in = 1'b0;
		for (int a = 8'h1F; a <= 8'h27; a++) rd(a[7:0], 8'h00);
		chk(oversample_ratio_out, 8'h01);
		$display("test reset values done");
		for (int i = 0; i < 7; i++) begin
			wr(8'h1F + i[7:0], 8'hFF);
			rd(8'h1F + i[7:0], msk[i]);
		end
		wr(8'h26, 8'hF8);
		rd(8'h26, 8'h38);
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00);
		$display("test reserved bits done");
		for (int i = 0; i < 8; i++) begin
			wr(8'h26, {2'b00, i[2:0], 3'b000});
			chk(oversample_ratio_out, 8'h01 << i);
		end
		$display("test oversample done");
		for (int i = 0; i < 7; i++) wr(8'h1F + i[7:0], 8'h00);
		mp = 20'h00000;
		tmin = 12'h000;
		tmax = 12'h000;
		rd_all;
		for (int i = 0; i < 8; i++) measure(1'b0);
		rd_all;
		wr(8'h21, 8'h00);
		wr(8'h22, 8'h00);
		wr(8'h23, 8'h00);
		mp = 20'h00000;
		measure(1'b0);
		rd_all;
		$display("test capture done");
		wr(8'h26, 8'h01);
		act_sel = 1'b1;
		chk(active_mode_out, 1'b1);
		measure(1'b1);
		// one-shot while active keeps its bit set
		measure(1'b0);
		wr(8'h26, 8'h00);
		rd_all;
		$display("test active mode done");
		// field change in standby, then reset from active
		wr(8'h26, 8'h28);
		wr(8'h26, 8'h29);
		chk(oversample_ratio_out, 8'h20);
		wr(8'h26, 8'h04);
		@(posedge core_clk_in);
		#1 chk(active_mode_out, 1'b0);
		@(posedge core_clk_in);
		#1 chk(serial_reset_out, 1'b1);
		chk(oversample_ratio_out, 8'h01);
		mp = 20'h00000;
		tmin = 12'h000;
		tmax = 12'h000;
		rd_all;
		rd(8'h26, 8'h00);
		$display("test software reset done");
		repeat (4) @(posedge core_clk_in);
		report_and_stop;
	end
endmodule : xcc_top_tb
